// *** src/pcs_pkg.sv ***
// shared constants of the program counter, return stack and indirect port
package pcs_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses on the apb bus
  // ----------------------------------------------------------------
  localparam logic [11:0] PCS_LOW_OFF = 12'h000;
  localparam logic [11:0] PCS_LATCH_OFF = 12'h004;
  localparam logic [11:0] PCS_PTR_OFF = 12'h008;
  localparam logic [11:0] PCS_PORT_OFF = 12'h00c;
  localparam logic [11:0] PCS_CMD_OFF = 12'h010;
  localparam logic [11:0] PCS_LIT_OFF = 12'h014;
  localparam logic [1:0] PCS_WIN_TAG = 2'h1;
  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int PCS_PC_W = 13;
  localparam int PCS_LATCH_W = 5;
  localparam int PCS_PAGE_W = 11;
  localparam int PCS_CMD_OP_LSB = 12;
  localparam int PCS_BANK_BIT = 8;
  localparam int PCS_STACK_DEPTH = 8;
  localparam int PCS_DATA_DEPTH = 256;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [12:0] PCS_PC_RST = 13'h0000;
  localparam logic [4:0] PCS_LATCH_RST = 5'h00;
  localparam logic [7:0] PCS_PTR_RST = 8'h00;
  // ----------------------------------------------------------------
  // flow commands written by the decoder
  // ----------------------------------------------------------------
  localparam logic [2:0] PCS_OP_NOP = 3'h0;
  localparam logic [2:0] PCS_OP_CALL = 3'h1;
  localparam logic [2:0] PCS_OP_GOTO = 3'h2;
  localparam logic [2:0] PCS_OP_RET = 3'h3;
  localparam logic [2:0] PCS_OP_RETLIT = 3'h4;
  localparam logic [2:0] PCS_OP_RETINT = 3'h5;
  localparam logic [2:0] PCS_OP_IRQ = 3'h6;
  localparam logic [2:0] PCS_OP_ADD = 3'h7;
endpackage

// *** src/pcs_ifs.sv ***
// carriers between the core and its stack and data store
`timescale 1ns/10ps
interface pcs_stack_if #(parameter int WIDTH = 13);
  logic push;
  logic pop;
  logic [WIDTH-1:0] din;
  logic [WIDTH-1:0] top;
  modport core (output push, output pop, output din, input top);
  modport stk (input push, input pop, input din, output top);
endinterface

interface pcs_ind_if;
  logic req;
  logic we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output req, output we, output addr, output wdata, input rdata);
  modport mem (input req, input we, input addr, input wdata, output rdata);
endinterface

// *** src/pcs_stack.sv ***
// circular hardware return stack
`timescale 1ns/10ps
module pcs_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic clk, // core clock
  input wire logic rstn, // async reset, active low
  pcs_stack_if.stk sif // push, pop and top of stack
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] ptr;
  } pcs_stk_state_t;

  pcs_stk_state_t st_r;
  pcs_stk_state_t st_nxt;
  logic [PW-1:0] top_idx;

  // top is the slot below the pointer; pointer is hidden from software
  assign top_idx = PW'(st_r.ptr - 1'b1);
  assign sif.top = st_r.mem[top_idx];

  // push wins if both arrive; no overflow flag, old slots get overwritten
  always_comb begin
    st_nxt = st_r;
    if (sif.push) begin
      st_nxt.mem[st_r.ptr] = sif.din; // [RULE_08]
      st_nxt.ptr = PW'(st_r.ptr + 1'b1); // [RULE_12]
    end else if (sif.pop) begin
      st_nxt.ptr = top_idx; // [RULE_17]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  push_wrap_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_12]
    sif.push |=> st_r.ptr == PW'($past(st_r.ptr) + 1))
    else $error("stack pointer did not advance by one on push");
  push_top_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_08]
    sif.push |=> sif.top == $past(sif.din))
    else $error("pushed value not on top of stack");
  pop_back_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_17]
    (sif.pop && !sif.push) |=> st_r.ptr == PW'($past(st_r.ptr) - 1))
    else $error("stack pointer did not step back on pop");
endmodule

// *** src/pcs_indirect.sv ***
// data store reached directly or through the indirect pointer
`timescale 1ns/10ps
module pcs_indirect #(
  parameter int DEPTH = 256
) (
  input wire logic clk, // core clock
  input wire logic rstn, // async reset, active low
  pcs_ind_if.mem iif // access from the core
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] ram;
  } pcs_ind_state_t;

  pcs_ind_state_t st_r;
  pcs_ind_state_t st_nxt;
  logic [7:0] idx;
  logic self_hit;

  // bank bit sits above the pointer but is dropped: lower bank only
  assign idx = iif.addr[7:0]; // [RULE_16]
  assign self_hit = (idx == 8'h00);
  // the port itself has no storage and reads as zero
  assign iif.rdata = self_hit ? 8'h00 : st_r.ram[idx]; // [RULE_14]

  // a write aimed at the port is a no-op
  always_comb begin
    st_nxt = st_r;
    if (iif.req && iif.we && !self_hit) begin
      st_nxt.ram[idx] = iif.wdata; // [RULE_15]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  self_read_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_14]
    (iif.req && !iif.we && self_hit) |-> iif.rdata == 8'h00)
    else $error("read of the port through itself not zero");
  self_write_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_15]
    (iif.req && iif.we && self_hit) |=> st_r == $past(st_r))
    else $error("write to the port through itself changed data");
  data_write_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_13]
    (iif.req && iif.we && !self_hit) |=> st_r.ram[$past(idx)] == $past(iif.wdata))
    else $error("indirect write did not reach the target");
endmodule

// *** src/pcs_top.sv ***
// program counter, return stack and indirect access behind an apb slave
// Functional notes
// [RULE_01] 13-bit counter; low byte software readable, writable
// [RULE_02] upper five bits only loaded from latch; ret and irq load them from stack or IRQ_VECTOR, call/goto 10:8 from arg
// [RULE_03] every reset clears the whole counter
// [RULE_04] low byte write loads upper bits from latch
// [RULE_05] call/goto: 11 instruction bits, latch bits 4:3
// [RULE_06] low byte add wraps, no carry into latch
// [RULE_07] call or interrupt saves full 13-bit counter
// [RULE_08] hidden stack, eight deep, thirteen wide
// [RULE_09] push on call or interrupt branch
// [RULE_10] pop on return, literal return, interrupt return
// [RULE_11] latch untouched by push or pop
// [RULE_12] circular stack, ninth push overwrites first
// [RULE_13] data port redirects to pointer's target register
// [RULE_14] port reading itself returns zero
// [RULE_15] port writing itself changes nothing
// [RULE_16] 9-bit address: bank bit above pointer, unused
// [RULE_17] push/pop same cycle as branch, wrap mod eight
// [RULE_18] latch: 5-bit writable, reset clear, load only
`timescale 1ns/10ps
module pcs_top #(
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
  input wire logic pclk, // core clock, 50 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb transfer done
  output logic pslverr, // apb error, unmapped address
  output logic [12:0] pc // program counter to fetch
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [12:0] pc;
    logic [4:0] latch;
    logic [7:0] ptr;
    logic bank;
    logic [7:0] lit;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pcs_top_state_t;

  pcs_top_state_t st_r;
  pcs_top_state_t st_nxt;

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  logic acc;
  logic done;
  logic wr_done;
  logic rd_acc;

  // first access cycle prepares the answer, the next one completes
  assign acc = psel & penable & ~st_r.ready;
  assign done = psel & penable & st_r.ready;
  assign wr_done = done & pwrite;
  assign rd_acc = acc & ~pwrite;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_low;
  logic hit_latch;
  logic hit_ptr;
  logic hit_port;
  logic hit_cmd;
  logic hit_lit;
  logic hit_win;
  logic hit_any;
  logic [7:0] win_addr;

  assign hit_low = (paddr == pcs_pkg::PCS_LOW_OFF);
  assign hit_latch = (paddr == pcs_pkg::PCS_LATCH_OFF);
  assign hit_ptr = (paddr == pcs_pkg::PCS_PTR_OFF);
  assign hit_port = (paddr == pcs_pkg::PCS_PORT_OFF);
  assign hit_cmd = (paddr == pcs_pkg::PCS_CMD_OFF);
  assign hit_lit = (paddr == pcs_pkg::PCS_LIT_OFF);
  // data window: one word per data byte, low two address bits zero
  assign hit_win = (paddr[11:10] == pcs_pkg::PCS_WIN_TAG) && (paddr[1:0] == 2'h0);
  assign win_addr = paddr[9:2];
  assign hit_any = hit_low | hit_latch | hit_ptr | hit_port | hit_cmd | hit_lit | hit_win;

  // ----------------------------------------------------------------
  // command fields
  // ----------------------------------------------------------------
  logic [2:0] op;
  logic [10:0] arg;
  logic cmd_go;
  logic do_call;
  logic do_goto;
  logic do_ret;
  logic do_retlit;
  logic do_retint;
  logic do_irq;
  logic do_add;
  logic do_pop;
  logic do_push;

  assign op = pwdata[pcs_pkg::PCS_CMD_OP_LSB +: 3];
  assign arg = pwdata[pcs_pkg::PCS_PAGE_W-1:0];
  assign cmd_go = wr_done & hit_cmd;
  assign do_call = cmd_go && (op == pcs_pkg::PCS_OP_CALL);
  assign do_goto = cmd_go && (op == pcs_pkg::PCS_OP_GOTO);
  assign do_ret = cmd_go && (op == pcs_pkg::PCS_OP_RET);
  assign do_retlit = cmd_go && (op == pcs_pkg::PCS_OP_RETLIT);
  assign do_retint = cmd_go && (op == pcs_pkg::PCS_OP_RETINT);
  assign do_irq = cmd_go && (op == pcs_pkg::PCS_OP_IRQ);
  assign do_add = cmd_go && (op == pcs_pkg::PCS_OP_ADD);
  assign do_pop = do_ret | do_retlit | do_retint;
  assign do_push = do_call | do_irq;

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  pcs_stack_if #(.WIDTH(pcs_pkg::PCS_PC_W)) stk_bus ();

  // push and branch share the same completing edge
  assign stk_bus.push = do_push; // [RULE_09] [RULE_17]
  assign stk_bus.pop = do_pop; // [RULE_10] [RULE_17]
  // full counter saved, so a return needs no page fix-up
  assign stk_bus.din = st_r.pc; // [RULE_07]

  pcs_stack #(
    .DEPTH(pcs_pkg::PCS_STACK_DEPTH),
    .WIDTH(pcs_pkg::PCS_PC_W)
  ) u_stack (
    .clk(pclk),
    .rstn(presetn),
    .sif(stk_bus)
  );

  // ----------------------------------------------------------------
  // data store and indirect port
  // ----------------------------------------------------------------
  pcs_ind_if ind_bus ();
  logic ind_sel;
  logic use_ptr;

  // direct access to data address zero is the port too
  assign use_ptr = hit_port | (hit_win && (win_addr == 8'h00)); // [RULE_13]
  assign ind_sel = hit_port | hit_win;
  // reads sampled in the preparing cycle, writes at completion
  assign ind_bus.req = ind_sel & (rd_acc | wr_done);
  assign ind_bus.we = pwrite;
  assign ind_bus.addr = use_ptr ? {st_r.bank, st_r.ptr} : {1'b0, win_addr}; // [RULE_16]
  assign ind_bus.wdata = pwdata[7:0];

  pcs_indirect #(
    .DEPTH(pcs_pkg::PCS_DATA_DEPTH)
  ) u_data (
    .clk(pclk),
    .rstn(presetn),
    .iif(ind_bus)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  // upper counter bits have no read path at all
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_low) begin
      rd_val[7:0] = st_r.pc[7:0]; // [RULE_01] [RULE_02]
    end else if (hit_latch) begin
      rd_val[pcs_pkg::PCS_LATCH_W-1:0] = st_r.latch;
    end else if (hit_ptr) begin
      rd_val[7:0] = st_r.ptr;
      rd_val[pcs_pkg::PCS_BANK_BIT] = st_r.bank;
    end else if (hit_lit) begin
      rd_val[7:0] = st_r.lit;
    end else if (ind_sel) begin
      rd_val[7:0] = ind_bus.rdata; // [RULE_13]
    end
  end

  // ----------------------------------------------------------------
  // next counter value
  // ----------------------------------------------------------------
  logic [7:0] add_low;
  logic [12:0] page_tgt;

  // eight-bit sum: a table crossing 0xff needs software to bump the latch
  assign add_low = 8'(st_r.pc[7:0] + arg[7:0]); // [RULE_06]
  assign page_tgt = {st_r.latch[4:3], arg}; // [RULE_05]

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = acc;
    if (acc) begin
      st_nxt.rdata = (pwrite || !hit_any) ? 32'h0000_0000 : rd_val;
      st_nxt.err = ~hit_any;
    end else begin
      st_nxt.err = 1'b0;
    end
    if (wr_done && hit_low) begin
      st_nxt.pc = {st_r.latch, pwdata[7:0]}; // [RULE_04] [RULE_01]
    end
    // latch is a plain holding register, never moved by the stack
    if (wr_done && hit_latch) begin
      st_nxt.latch = pwdata[pcs_pkg::PCS_LATCH_W-1:0]; // [RULE_18]
    end
    if (wr_done && hit_ptr) begin
      st_nxt.ptr = pwdata[7:0];
      st_nxt.bank = pwdata[pcs_pkg::PCS_BANK_BIT];
    end
    // one command per transfer; nop leaves everything alone
    if (do_call || do_goto) begin
      st_nxt.pc = page_tgt; // [RULE_05]
    end
    if (do_irq) begin
      st_nxt.pc = IRQ_VECTOR; // [RULE_09]
    end
    if (do_pop) begin
      st_nxt.pc = stk_bus.top; // [RULE_10] [RULE_11]
    end
    if (do_retlit) begin
      st_nxt.lit = arg[7:0];
    end
    if (do_add) begin
      st_nxt.pc = {st_r.latch, add_low}; // [RULE_06] [RULE_04]
    end
  end

  // all reset kinds arrive on presetn and clear the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.pc <= pcs_pkg::PCS_PC_RST; // [RULE_03]
      st_r.latch <= pcs_pkg::PCS_LATCH_RST; // [RULE_18]
      st_r.ptr <= pcs_pkg::PCS_PTR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign pc = st_r.pc;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  pc_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    $rose(presetn) |-> (st_r.pc == 13'h0000 && st_r.latch == 5'h00))
    else $error("counter or latch not clear after reset");
  low_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    (wr_done && hit_low) |=> pc == {$past(st_r.latch), $past(pwdata[7:0])})
    else $error("low byte write did not load all 13 bits");
  page_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    (do_call || do_goto) |=>
      (pc[12:11] == $past(st_r.latch[4:3]) && pc[10:0] == $past(arg)))
    else $error("call or goto target not paged from latch");
  add_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    do_add |=> (pc[12:8] == $past(st_r.latch) && $stable(st_r.latch)))
    else $error("offset add carried into the upper bits");
  call_save_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
    (do_call || do_irq) |=> stk_bus.top == $past(pc))
    else $error("branch did not push the full counter");
  ret_pop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    do_call ##1 (!do_push && !do_pop && !wr_done) [*2] ##1 do_ret
      |=> pc == $past(pc, 4))
    else $error("return did not restore the saved counter");
  latch_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
    (stk_bus.push || stk_bus.pop) |=> $stable(st_r.latch))
    else $error("latch moved with the stack");
  pc_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    !(wr_done && (hit_low || hit_cmd)) |=> $stable(pc))
    else $error("counter changed without a load");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    acc |=> (pready && pslverr == !$past(hit_any)) ##1 !pready)
    else $error("bus answer not a single cycle after access");
  irq_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
    do_irq |=> pc == IRQ_VECTOR)
    else $error("interrupt entry did not reach the vector");
  lit_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    do_retlit |=> st_r.lit == $past(arg[7:0]))
    else $error("literal return did not keep its literal");
  latch_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
    (wr_done && hit_latch) |=> st_r.latch == $past(pwdata[4:0]))
    else $error("latch write not taken");
  upper_hide_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    (rd_acc && hit_low) |=> prdata[31:8] == 24'h000000)
    else $error("upper counter bits visible on low byte read");
endmodule

// *** sim/pcs_decoder_model.sv ***
// apb master model standing in for the instruction decoder
`timescale 1ns/10ps
module pcs_decoder_model (
  input wire logic pclk, // core clock
  output logic psel, // apb select
  output logic penable, // apb access phase
  output logic pwrite, // apb direction
  output logic [11:0] paddr, // apb byte address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb transfer done
  input wire logic pslverr, // apb error
  output logic hung // a transfer never completed
);
  // ----------------------------------------------------------------
  // idle levels at time zero
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // entered right after a rising edge; request held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hung = 1'b1;
    rd = prdata;
    err = pslverr;
  endtask
  // stale lines flip so nobody can lean on a released value
  task automatic release_bus();
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the program counter, stack and indirect port
`timescale 1ns/10ps
module tb_top;
  localparam logic [12:0] VEC = 13'h0ab4; // entry target, arbitrary
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, r, d;
  logic [12:0] pc, pc_m;
  logic [4:0] latch_m;
  logic [8:0] ptr_m;
  logic [7:0] lit_m;
  logic [2:0] sp_m;
  logic [12:0] stk_m [8];
  logic [7:0] ram_m [256];
  int miscompares, total_checks;
  integer seed;
  pcs_top #(.IRQ_VECTOR(VEC)) u_pcs_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc(pc));
  pcs_decoder_model u_pcs_decoder_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hung(hung));
  // ----------------------------------------------------------------
  // compare tasks and verdict
  // ----------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_pc(input logic [12:0] e, input logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch pc expected %h seen %h", e, g);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  task automatic model_reset();
    pc_m = 13'h0;
    latch_m = 5'h0;
    ptr_m = 9'h0;
    lit_m = 8'h0;
    sp_m = 3'h0;
    for (int i = 0; i < 8; i++) stk_m[i] = 13'h0;
    for (int i = 0; i < 256; i++) ram_m[i] = 8'h0;
  endtask
  // pointer naming the port itself reads as zero
  function automatic logic [7:0] port_rd();
    return (ptr_m[7:0] == 8'h00) ? 8'h00 : ram_m[ptr_m[7:0]];
  endfunction
  function automatic logic [32:0] exp_read(input logic [11:0] x);
    if (x[11:10] == pcs_pkg::PCS_WIN_TAG && x[1:0] == 2'h0)
      return {25'h0, (x[9:2] == 8'h00) ? port_rd() : ram_m[x[9:2]]};
    case (x)
      pcs_pkg::PCS_LOW_OFF: return {25'h0, pc_m[7:0]};
      pcs_pkg::PCS_LATCH_OFF: return {28'h0, latch_m};
      pcs_pkg::PCS_PTR_OFF: return {24'h0, ptr_m};
      pcs_pkg::PCS_PORT_OFF: return {25'h0, port_rd()};
      pcs_pkg::PCS_CMD_OFF: return 33'h0;
      pcs_pkg::PCS_LIT_OFF: return {25'h0, lit_m};
      default: return {1'b1, 32'h0};
    endcase
  endfunction
  // circular lifo: any pointer convention gives the same pop order
  task automatic model_cmd(input logic [2:0] op, input logic [10:0] arg);
    case (op)
      pcs_pkg::PCS_OP_CALL, pcs_pkg::PCS_OP_IRQ: begin
        sp_m = sp_m + 3'h1;
        stk_m[sp_m] = pc_m;
        pc_m = (op == pcs_pkg::PCS_OP_IRQ) ? VEC : {latch_m[4:3], arg};
      end
      pcs_pkg::PCS_OP_GOTO: pc_m = {latch_m[4:3], arg};
      pcs_pkg::PCS_OP_RET, pcs_pkg::PCS_OP_RETLIT, pcs_pkg::PCS_OP_RETINT: begin
        pc_m = stk_m[sp_m];
        sp_m = sp_m - 3'h1;
        if (op == pcs_pkg::PCS_OP_RETLIT) lit_m = arg[7:0];
      end
      pcs_pkg::PCS_OP_ADD: pc_m = {latch_m, pc_m[7:0] + arg[7:0]};
      default: ;
    endcase
  endtask
  task automatic model_write(input logic [11:0] x, input logic [31:0] v);
    if (x[11:10] == pcs_pkg::PCS_WIN_TAG && x[1:0] == 2'h0) begin
      if (x[9:2] != 8'h00) ram_m[x[9:2]] = v[7:0];
      else if (ptr_m[7:0] != 8'h00) ram_m[ptr_m[7:0]] = v[7:0];
    end else begin
      case (x)
        pcs_pkg::PCS_LOW_OFF: pc_m = {latch_m, v[7:0]};
        pcs_pkg::PCS_LATCH_OFF: latch_m = v[4:0];
        pcs_pkg::PCS_PTR_OFF: ptr_m = v[8:0];
        pcs_pkg::PCS_PORT_OFF: if (ptr_m[7:0] != 8'h00) ram_m[ptr_m[7:0]] = v[7:0];
        pcs_pkg::PCS_CMD_OFF: model_cmd(v[14:12], v[10:0]);
        default: ;
      endcase
    end
  endtask
  // one apb transfer, expectation worked out before the request goes out
  task automatic bus(input logic w, input logic [11:0] x, input logic [31:0] v);
    logic [31:0] rd;
    logic err;
    logic [32:0] ex;
    ex = exp_read(x);
    u_pcs_decoder_model.xfer(w, x, v, rd, err);
    chk1($sformatf("pslverr %h", x), ex[32], err);
    if (!w) chk32($sformatf("read %h", x), ex[31:0], rd);
    else model_write(x, v);
  endtask
  // ----------------------------------------------------------------
  // clock, pc watch, watchdog
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(negedge pclk) begin
    chk_pc(pc_m, pc);
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 87670;
    presetn = 1'b0;
    model_reset();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) bus(1'b0, 12'(i * 4), 32'h0);
    bus(1'b1, pcs_pkg::PCS_LATCH_OFF, 32'hffff_ff1b);
    bus(1'b1, pcs_pkg::PCS_LOW_OFF, 32'h0000_00f0);
    bus(1'b1, pcs_pkg::PCS_CMD_OFF, {17'h0, pcs_pkg::PCS_OP_ADD, 12'h020});
    bus(1'b0, pcs_pkg::PCS_LATCH_OFF, 32'h0);
    // every flow command once, back to back
    for (int op = 0; op < 8; op++) begin
      bus(1'b1, pcs_pkg::PCS_CMD_OFF, {17'h0, 3'(op), 12'h5a5});
    end
    bus(1'b0, pcs_pkg::PCS_LIT_OFF, 32'h0);
    // nine nested calls then nine returns: the ninth overwrote the first
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, pcs_pkg::PCS_LOW_OFF, 32'(i + 8'h40));
      bus(1'b1, pcs_pkg::PCS_CMD_OFF, {17'h0, pcs_pkg::PCS_OP_CALL, 12'(i)});
    end
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, pcs_pkg::PCS_CMD_OFF, {17'h0, pcs_pkg::PCS_OP_RET, 12'h0});
    end
    bus(1'b0, pcs_pkg::PCS_LATCH_OFF, 32'h0);
    // port pointing at itself, then bank bit set
    bus(1'b1, pcs_pkg::PCS_PTR_OFF, 32'h0);
    bus(1'b1, pcs_pkg::PCS_PORT_OFF, 32'h77);
    bus(1'b0, pcs_pkg::PCS_PORT_OFF, 32'h0);
    bus(1'b0, 12'h400, 32'h0);
    bus(1'b1, pcs_pkg::PCS_PTR_OFF, 32'h105);
    bus(1'b1, pcs_pkg::PCS_PORT_OFF, 32'h3c);
    bus(1'b0, 12'h414, 32'h0);
    bus(1'b1, pcs_pkg::PCS_LIT_OFF, 32'hff);
    bus(1'b0, 12'h018, 32'h0);
    bus(1'b0, 12'h402, 32'h0);
    // random mix of registers, window and unmapped places
    for (int k = 0; k < 500; k++) begin
      r = $random(seed);
      d = $random(seed);
      if (r[3:0] < 4'h6) a = {6'h0, r[3:0], 2'h0};
      else if (r[3:0] < 4'he) a = {2'b01, r[11:4], 2'h0};
      else a = r[27:16];
      bus(r[31], a, d);
      if (r[30]) u_pcs_decoder_model.release_bus();
    end
    // reset in mid-run clears counter and latch
    u_pcs_decoder_model.release_bus();
    presetn <= 1'b0;
    model_reset();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, pcs_pkg::PCS_LATCH_OFF, 32'h0);
    bus(1'b0, pcs_pkg::PCS_LOW_OFF, 32'h0);
    u_pcs_decoder_model.release_bus();
    chk1("hung", 1'b0, hung);
    complete_run();
  end
endmodule
